// file: core/btsb_exec.sv
// Purpose: Decode and execute of the bit test/skip-on-zero and bit set words.
// Assumes: One instruction per clk; rf_rdata holds the register addressed by
//          instr_word[6:0] in the same cycle instr_valid is high.
// Notes:   Results appear one edge after the word is taken.
//
// Operation
// [RQ1] Decode 0110 top bits as skip-on-zero test
// [RQ2] Skip next instruction only when bit zero
// [RQ3] Discard prefetched word, run idle operation instead
// [RQ4] Test takes one cycle, two when skipping
// [RQ5] Decode 0101 top bits, set selected bit
// [RQ6] No status flag change, other bits kept
`timescale 1ns/10ps
`default_nettype none
`include "btsb_cfg.svh"

module btsb_exec (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // Fetch stage
  input  wire btsb_pkg::btsb_word_type instr_word,
  input  wire logic                    instr_valid,
  // Register file read side
  input  wire btsb_pkg::btsb_data_type rf_rdata,
  // Register file write side
  output logic                         rf_we,
  output btsb_pkg::btsb_addr_type      rf_waddr,
  output btsb_pkg::btsb_data_type      rf_wdata,
  // Program flow
  output logic                         discard_fetch,
  output logic                         idle_op_exec,
  output logic                         instr_done,
  // Arithmetic status
  output logic                         status_we
);
  import btsb_pkg::*;

  btsb_regs_type r;
  btsb_regs_type next_r;

  btsb_data_type set_data;
  logic          bit_value;
  logic          is_test;
  logic          is_set;
  btsb_sel_type  bit_sel;
  btsb_addr_type reg_addr;

  // Field extraction from the word on the fetch port
  assign bit_sel  = instr_word[`BTSB_BIT_HI:`BTSB_BIT_LO];
  assign reg_addr = instr_word[`BTSB_ADDR_HI:`BTSB_ADDR_LO];

  // [RQ1] Skip test decode
  assign is_test = (instr_word[`BTSB_OPC_HI:`BTSB_OPC_LO] == `BTSB_OPC_TEST_SKIP);
  // [RQ5] Bit set decode
  assign is_set  = (instr_word[`BTSB_OPC_HI:`BTSB_OPC_LO] == `BTSB_OPC_SET_BIT);

  // Bit lane logic shared by both instructions
  btsb_bit_unit u_bit_unit (
    .data_in   (rf_rdata),
    .bit_sel   (bit_sel),
    .set_data  (set_data),
    .bit_value (bit_value)
  );

  // Next-state logic; pulses default low each cycle
  always_comb begin
    next_r               = r;
    next_r.rf_we         = 1'b0;
    next_r.discard_fetch = 1'b0;
    next_r.idle_op_exec  = 1'b0;
    next_r.instr_done    = 1'b0;
    // [RQ6] Status flags never written
    next_r.status_we     = 1'b0;
    unique case (r.state)
      BTSB_RUN: begin
        if (instr_valid && is_test) begin
          // [RQ2] Skip only on zero
          if (!bit_value) begin
            // [RQ3] Drop prefetched word
            next_r.discard_fetch = 1'b1;
            next_r.state         = BTSB_SKIP;
          end else begin
            // [RQ4] Single cycle, no skip
            next_r.instr_done = 1'b1;
          end
        end else if (instr_valid && is_set) begin
          // [RQ5] Write back with bit forced
          next_r.rf_we      = 1'b1;
          next_r.rf_waddr   = reg_addr;
          next_r.rf_wdata   = set_data;
          next_r.instr_done = 1'b1;
        end
      end
      BTSB_SKIP: begin
        // [RQ3] Idle operation replaces word
        // [RQ4] Second cycle closes skip
        next_r.idle_op_exec = 1'b1;
        next_r.instr_done   = 1'b1;
        next_r.state        = BTSB_RUN;
      end
      default: begin
        // Illegal one-hot code recovers to the run state
        next_r.state = BTSB_RUN;
      end
    endcase
  end

  // State register; reset gives a quiet run state
  always_ff @(posedge clk) begin
    if (rst) begin
      r.state         <= BTSB_RUN;
      r.rf_we         <= 1'b0;
      r.rf_waddr      <= `BTSB_RST_ADDR;
      r.rf_wdata      <= `BTSB_RST_DATA;
      r.discard_fetch <= 1'b0;
      r.idle_op_exec  <= 1'b0;
      r.instr_done    <= 1'b0;
      r.status_we     <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from the state flops
  assign rf_we         = r.rf_we;
  assign rf_waddr      = r.rf_waddr;
  assign rf_wdata      = r.rf_wdata;
  assign discard_fetch = r.discard_fetch;
  assign idle_op_exec  = r.idle_op_exec;
  assign instr_done    = r.instr_done;
  assign status_we     = r.status_we;

  // Checks, all in the single clk domain
  // A new word may be taken in the cycle that closes a skip, so no check
  // looks at the state one cycle beyond the idle operation
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Skip test with a zero bit must enter the skip cycle
  a_skip_decode_zero: assert property ( // [RQ1]
    (r.state == BTSB_RUN) && instr_valid && is_test && !rf_rdata[bit_sel]
    |=> discard_fetch && (r.state == BTSB_SKIP) && !instr_done)
    else $error("skip test with zero bit did not skip");

  // Skip test with a one bit must finish at once, no skip
  a_skip_only_zero: assert property ( // [RQ2]
    (r.state == BTSB_RUN) && instr_valid && is_test && rf_rdata[bit_sel]
    |=> instr_done && !discard_fetch && !rf_we)
    else $error("skip test with one bit skipped or failed to finish");

  // The word after a skip is replaced by an idle operation, never written
  a_skip_idle_sub: assert property ( // [RQ3]
    discard_fetch |=> idle_op_exec && !rf_we && !discard_fetch)
    else $error("discarded word was not replaced by idle operation");

  // Skipped test completes exactly two cycles after it was taken
  a_skip_two_cycle: assert property ( // [RQ4]
    (r.state == BTSB_RUN) && instr_valid && is_test && !rf_rdata[bit_sel]
    |=> !instr_done ##1 (instr_done && (r.state == BTSB_RUN)))
    else $error("skipped test did not take two cycles");

  // Bit set writes the addressed register with the selected bit high
  a_set_write_back: assert property ( // [RQ5]
    (r.state == BTSB_RUN) && instr_valid && is_set
    |=> rf_we && instr_done && (rf_waddr == $past(reg_addr))
        && rf_wdata[$past(bit_sel)])
    else $error("bit set did not write the addressed register");

  // Only the selected bit may differ from the value read
  a_set_keep_other: assert property ( // [RQ6]
    rf_we |-> ((rf_wdata & ~(8'h01 << $past(bit_sel)))
               == ($past(rf_rdata) & ~(8'h01 << $past(bit_sel)))))
    else $error("bit set disturbed an unselected bit");

  // Status flags stay untouched in every completion cycle
  a_status_quiet: assert property ( // [RQ6]
    instr_done |-> !status_we)
    else $error("status flags written by bit instruction");

  // A write only ever follows a decoded bit set word
  a_write_cause: assert property ( // [RQ5]
    rf_we |-> $past(instr_valid) && ($past(instr_word[13:10]) == 4'h5))
    else $error("register write without a bit set word");

  // Words that are neither test nor set leave every pulse low
  a_other_word_quiet: assert property ( // [RQ1]
    (r.state == BTSB_RUN) && (!instr_valid || (!is_test && !is_set))
    |=> !rf_we && !discard_fetch && !instr_done && !idle_op_exec)
    else $error("undecoded word produced an action");

  // The word offered in the dropped slot is ignored outright
  a_skip_word_ignored: assert property ( // [RQ3]
    (r.state == BTSB_SKIP)
    |=> !rf_we && !discard_fetch && (r.state == BTSB_RUN))
    else $error("word in the dropped slot was acted on");

  // An idle operation only ever follows an announced skip
  a_idle_needs_skip: assert property ( // [RQ3]
    idle_op_exec |-> $past(discard_fetch))
    else $error("idle operation without a preceding skip");

  // The skip announcement cycle completes nothing yet
  a_skip_no_done: assert property ( // [RQ4]
    discard_fetch |-> !instr_done && !idle_op_exec && !rf_we)
    else $error("skip announcement overlapped a completion");

  // Completion comes from a taken word or the close of a skip
  a_done_cause: assert property ( // [RQ4]
    instr_done |-> ($past(instr_valid) && ($past(r.state) == BTSB_RUN))
                   || ($past(r.state) == BTSB_SKIP))
    else $error("completion pulse without a cause");

  // A set never starts the skip machinery
  a_set_no_skip: assert property ( // [RQ5]
    (r.state == BTSB_RUN) && instr_valid && is_set
    |=> !discard_fetch && !idle_op_exec && (r.state == BTSB_RUN))
    else $error("bit set started a skip");

  // Write address and data hold between sets; the reset edge is excluded
  a_set_data_hold: assert property ( // [RQ5]
    !rf_we && !$past(rst) |-> $stable(rf_waddr) && $stable(rf_wdata))
    else $error("write address or data moved without a set");

endmodule : btsb_exec

`default_nettype wire

// file: core/btsb_cfg.svh
// Purpose: Constants for the bit test/skip and bit set execute block.
// Assumes: 14-bit instruction words, 8-bit file registers, 7-bit addresses.
// Notes:   Definitions only; included by bare name.
`ifndef BTSB_CFG_SVH
`define BTSB_CFG_SVH

// Instruction word layout
`define BTSB_WORD_W        14
`define BTSB_OPC_HI        13
`define BTSB_OPC_LO        10
`define BTSB_BIT_HI        9
`define BTSB_BIT_LO        7
`define BTSB_ADDR_HI       6
`define BTSB_ADDR_LO       0

// Opcode values of the top four bits (01 10 and 01 01)
`define BTSB_OPC_TEST_SKIP 4'h6
`define BTSB_OPC_SET_BIT   4'h5

// Data widths
`define BTSB_DATA_W        8
`define BTSB_ADDR_W        7
`define BTSB_SEL_W         3

// Reset values
`define BTSB_RST_DATA      8'h00
`define BTSB_RST_ADDR      7'h00

// Cycle counts per instruction
`define BTSB_CYC_PLAIN     1
`define BTSB_CYC_SKIPPED   2

`endif

// file: core/btsb_pkg.sv
// Purpose: Types shared by the bit test/skip and bit set execute block.
// Assumes: Constants come from btsb_cfg.svh.
// Notes:   One-hot state codes are written out.
`include "btsb_cfg.svh"

package btsb_pkg;

  // Execution state, one-hot
  typedef enum logic [1:0] {
    BTSB_RUN  = 2'h1,
    BTSB_SKIP = 2'h2
  } btsb_state_type;

  typedef logic [`BTSB_WORD_W-1:0] btsb_word_type;
  typedef logic [`BTSB_DATA_W-1:0] btsb_data_type;
  typedef logic [`BTSB_ADDR_W-1:0] btsb_addr_type;
  typedef logic [`BTSB_SEL_W-1:0]  btsb_sel_type;

  // Whole registered state of the execute block
  typedef struct packed {
    btsb_state_type state;
    logic           rf_we;
    btsb_addr_type  rf_waddr;
    btsb_data_type  rf_wdata;
    logic           discard_fetch;
    logic           idle_op_exec;
    logic           instr_done;
    logic           status_we;
  } btsb_regs_type;

endpackage : btsb_pkg

// file: core/btsb_bit_unit.sv
// Purpose: Per-bit select, test and set of one file register byte.
// Assumes: Purely combinational; caller registers the results.
// Notes:   One generate loop covers all eight bit lanes.
`timescale 1ns/10ps
`default_nettype none
`include "btsb_cfg.svh"

module btsb_bit_unit (
  // Operand
  input  wire btsb_pkg::btsb_data_type data_in,
  input  wire btsb_pkg::btsb_sel_type  bit_sel,
  // Results
  output wire btsb_pkg::btsb_data_type set_data,
  output wire logic                    bit_value
);
  import btsb_pkg::*;

  btsb_data_type hit;

  // Each lane either passes its bit or forces it high when selected
  genvar gi;
  generate
    for (gi = 0; gi < `BTSB_DATA_W; gi = gi + 1) begin : g_lane
      assign hit[gi]      = (bit_sel == btsb_sel_type'(gi));
      assign set_data[gi] = data_in[gi] | hit[gi];
    end
  endgenerate

  // Selected bit, a plain mux on the index
  assign bit_value = data_in[bit_sel];

endmodule : btsb_bit_unit

`default_nettype wire

// file: dv/btsb_rf_model.sv
// Purpose: Register file model that answers the bit test and set block.
// Assumes: Combinational read of the addressed byte, write on clk.
// Notes:   Write-through, so a set is seen by the very next word.
`timescale 1ns/10ps
`default_nettype none
module btsb_rf_model (
  // Clock
  input  wire logic                    clk,
  // Read side
  input  wire btsb_pkg::btsb_addr_type raddr,
  output var  btsb_pkg::btsb_data_type rdata,
  // Write side
  input  wire logic                    we,
  input  wire btsb_pkg::btsb_addr_type waddr,
  input  wire btsb_pkg::btsb_data_type wdata
);
  import btsb_pkg::*;
  btsb_data_type mem [128];
  // Bypass the pending write; without it back-to-back words read stale bytes
  always_comb begin
    rdata = (we && waddr == raddr) ? wdata : mem[raddr];
  end
  // Byte write
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end
endmodule : btsb_rf_model
`default_nettype wire

// file: dv/bit_test_skip_and_bit_set_exec_tb.sv
// Purpose: Self-checking bench for the bit test/skip and bit set block.
// Assumes: Register file model with write-through read.
// Notes:   Reference updates at each edge, compares at the falling edge.
`timescale 1ns/10ps
`default_nettype none
`include "btsb_cfg.svh"
module bit_test_skip_and_bit_set_exec_tb;
  import btsb_pkg::*;
  logic          clk, rst, instr_valid, armed, skip;
  logic          rf_we, discard_fetch, idle_op_exec, instr_done, status_we;
  logic          e_we, e_disc, e_idle, e_done;
  btsb_word_type instr_word;
  btsb_data_type rf_rdata, rf_wdata, e_data, d;
  btsb_data_type shadow [128];
  btsb_addr_type rf_waddr, e_addr;
  int            err_total, tests_run;

  btsb_exec i_dut (.clk(clk), .rst(rst), .instr_word(instr_word), .instr_valid(instr_valid),
    .rf_rdata(rf_rdata), .rf_we(rf_we), .rf_waddr(rf_waddr), .rf_wdata(rf_wdata),
    .discard_fetch(discard_fetch), .idle_op_exec(idle_op_exec), .instr_done(instr_done),
    .status_we(status_we));
  btsb_rf_model i_rf (.clk(clk), .raddr(instr_word[6:0]), .rdata(rf_rdata), .we(rf_we),
    .waddr(rf_waddr), .wdata(rf_wdata));

  // Clock
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Expected write-back of a set: read value with the chosen bit high
  function automatic btsb_data_type set_ref(input btsb_data_type v, input btsb_sel_type b);
    return v | (8'h01 << b);
  endfunction : set_ref

  // Skip is taken only when the tested bit reads zero
  function automatic logic skip_ref(input btsb_data_type v, input btsb_sel_type b);
    return (v[b] == 1'b0);
  endfunction : skip_ref

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim

  task automatic op(input logic [3:0] opc, input int b, input int a, input logic v = 1);
    @(posedge clk);
    instr_word  <= {opc, 3'(b), 7'(a)};
    instr_valid <= v;
  endtask : op

  // Reference: expected outputs of the word taken at this edge
  always @(posedge clk) begin
    d = shadow[instr_word[6:0]];
    {e_we, e_disc, e_idle, e_done} = 4'h0;
    if (rst) begin
      armed = 1;
      skip = 0;
      e_addr = 7'h00;
      e_data = 8'h00;
    end else if (skip) begin
      skip = 0;
      e_idle = 1;
      e_done = 1;
    end else if (instr_valid && instr_word[13:10] == `BTSB_OPC_TEST_SKIP) begin
      // skip only on a zero bit
      skip = skip_ref(d, instr_word[9:7]);
      e_disc = skip;
      e_done = !skip;
    end else if (instr_valid && instr_word[13:10] == `BTSB_OPC_SET_BIT) begin
      e_we = 1;
      e_done = 1;
      e_addr = instr_word[6:0];
      e_data = set_ref(d, instr_word[9:7]);
      shadow[e_addr] = e_data;
    end
  end

  // Compare where outputs have settled
  always @(negedge clk) begin
    if (armed) begin
      chk("rf_we", 8'(rf_we), 8'(e_we));
      chk("rf_waddr", 8'(rf_waddr), 8'(e_addr));
      chk("rf_wdata", rf_wdata, e_data);
      chk("discard_fetch", 8'(discard_fetch), 8'(e_disc));
      chk("idle_op_exec", 8'(idle_op_exec), 8'(e_idle));
      chk("instr_done", 8'(instr_done), 8'(e_done));
      chk("status_we", 8'(status_we), 8'h00);
    end
  end

  // Watchdog: the run needs about 420 cycles
  initial begin
    #20000;
    err_total++;
    end_sim();
  end

  initial begin
    rst = 1;
    instr_valid = 0;
    instr_word = 14'h0000;
    armed = 0;
    skip = 0;
    err_total = 0;
    tests_run = 0;
    void'($urandom(44084));
    for (int i = 0; i < 128; i++) begin
      shadow[i] = (i == 1) ? 8'hfe : 8'($urandom);
      i_rf.mem[i] = shadow[i];
    end
    repeat (5) @(posedge clk);
    rst <= 0;
    // set then test the same bit back to back
    op(4'h5, 7, 127);
    op(4'h6, 7, 127);
    op(4'h5, 0, 0);
    // skip taken; a set in the dropped slot must not write
    op(4'h6, 0, 1);
    op(4'h5, 0, 1);
    op(4'h6, 3, 1);
    op(4'h4, 0, 1);
    op(4'h6, 0, 1);
    op(4'h6, 0, 1);
    op(4'h5, 1, 2, 0);
    // Random words, mostly the two opcodes, with a reset in mid-run
    for (int i = 0; i < 400; i++) begin
      rst <= (i == 200);
      op($urandom_range(3) ? 4'(5 + $urandom_range(1)) : 4'($urandom_range(15)),
        $urandom_range(7), $urandom_range(127), $urandom_range(3) != 0);
    end
    repeat (3) @(posedge clk);
    end_sim();
  end
endmodule : bit_test_skip_and_bit_set_exec_tb
`default_nettype wire
